// ### bench/ssap_host.sv
/* Host model of the read-out link: drives chip select and shift clock.
   Assumes the bench calls run_frame and reads rx_word on rx_valid. */
module ssap_host
	import ssap_pkg::*;
(
	input wire logic clk,
	input ssap_sdo_s serial_data_out,
	output logic cs_n,
	output logic sck,
	output logic [15:0] rx_word,
	output logic rx_valid,
	output logic end_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pin;
	// A released pin shows the inverse of the last level, so Hi-Z is never read as data
	assign pin = serial_data_out.oe ? serial_data_out.data : ~serial_data_out.data;
	// Idle levels: deselected, shift clock parked low between frames
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		rx_word = 16'h0000;
		rx_valid = 1'b0;
		end_oe = 1'b0;
	end
	// One frame of n shift clocks of 125 ns (13 + 12 system clocks), sampled just before each fall.
	// Pins move on system clock edges by non-blocking assignment; the port resynchronises them.
	task automatic run_frame(input int n);
		@(posedge clk);
		rx_word <= 16'h0000;
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (13) @(posedge clk);
			sck <= 1'b1;
			repeat (12) @(posedge clk);
			rx_word <= {rx_word[14:0], pin};
			sck <= 1'b0;
		end
		repeat (13) @(posedge clk);
		end_oe <= serial_data_out.oe;
		cs_n <= 1'b1;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (200) @(posedge clk);
	endtask : run_frame
endmodule : ssap_host

// ### bench/ssap_port_test.sv
/* Self-checking bench of the read-out port with a host model on the link.
   Assumes the wake parameter shortened to 100 ns (20 clock cycles). */
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module ssap_port_test
	import ssap_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, srst, cs_n, sck, sample_strobe, conv_step, conv_done, powered, rx_valid, end_oe;
	logic [RES_W-1:0] sample_code, result_code, c;
	logic [15:0] rx_word, w;
	ssap_sdo_s serial_data_out;
	logic [15:0] exp_word[$];
	logic [RES_W-1:0] exp_code[$];
	int failures = 0, tests_run = 0, step_cnt = 0, strobe_cnt = 0, low_cnt = 0, frames = 0;
	ssap_port #(.WAKE_NS(100)) ssap_port_i (.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck),
		.sample_code(sample_code), .serial_data_out(serial_data_out),
		.sample_strobe(sample_strobe), .conv_step(conv_step), .conv_done(conv_done),
		.result_code(result_code), .powered(powered));
	ssap_host ssap_host_i (.clk(clk), .serial_data_out(serial_data_out), .cs_n(cs_n),
		.sck(sck), .rx_word(rx_word), .rx_valid(rx_valid), .end_oe(end_oe));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Watcher: each result takes the oldest note off its queue
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			w = exp_word.pop_front();
			`CHK(rx_word, w)
		end
		if (conv_done === 1'b1) begin
			c = exp_code.size() > 0 ? exp_code.pop_front() : ~result_code;
			`CHK(result_code, c)
		end
		if (conv_step === 1'b1) step_cnt++;
		if (sample_strobe === 1'b1) strobe_cnt++;
		if (powered === 1'b0 && cs_n === 1'b0) low_cnt++;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Frame of n clocks; the expected word is the frame cut to what n clocks shift out
	task automatic do_frame(input logic [RES_W-1:0] code, input int n, input bit done);
		@(posedge clk);
		sample_code <= code;
		exp_word.push_back({2'b00, code, 2'b00} >> (16 - n));
		if (done) exp_code.push_back(code);
		step_cnt = 0;
		frames++;
		ssap_host_i.run_frame(n);
		`CHK(step_cnt, n)
		`CHK(end_oe, n < 16)
		`CHK(serial_data_out.oe, 1'b0)
	endtask : do_frame
	// Watchdog sized well beyond the roughly 33 us of frames
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		srst = 1'b1;
		sample_code = 12'h000;
		void'($urandom(32'hDA3A));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(serial_data_out.oe, 1'b0)
		`CHK(powered, 1'b1)
		do_frame(12'h000, 16, 1);
		do_frame(12'hFFF, 16, 1);
		do_frame(12'hA5A, 16, 1);
		repeat (3) do_frame(12'($urandom), 16, 1);
		do_frame(12'($urandom), 14, 1);
		do_frame(12'($urandom), 5, 0);
		do_frame(12'($urandom), 16, 1);
		do_frame(12'($urandom), 1, 0);
		`CHK(powered, 1'b0)
		low_cnt = 0;
		do_frame(12'($urandom), 16, 0);
		`CHK(low_cnt >= 20 && low_cnt <= 25, 1'b1)
		`CHK(powered, 1'b1)
		do_frame(12'($urandom), 14, 1);
		`CHK(exp_code.size(), 0)
		`CHK(strobe_cnt, frames)
		tally_and_finish();
	end
endmodule : ssap_port_test

// ### logic/ssap_pkg.sv
/*
 * Shared constants and types of the serial sampling converter read-out port:
 * frame layout, bit indices, timing figures and the pin carrier struct.
 * Assumes a single 200 MHz system clock for all logic that uses it.
 */
package ssap_pkg;

	// System clock period
	localparam int CLK_PERIOD_NS = 5;

	// Power-up time from sleep; 1000 ns for the slow variant, 333 ns for the fast one
	localparam int WAKE_DELAY_NS = 1000;

	// Frame layout: two leading zeros, result MSB first, two trailing zeros
	localparam int RES_W = 12;
	localparam int LEAD_ZEROS = 2;
	localparam int TRAIL_ZEROS = 2;
	localparam int FRAME_W = LEAD_ZEROS + RES_W + TRAIL_ZEROS;
	localparam int CNT_W = 4;

	// Bit positions counted in shift clock falls since chip select fell
	localparam logic [CNT_W-1:0] FIRST_RES_IDX = 4'h2;
	localparam logic [CNT_W-1:0] DONE_IDX = 4'hD;
	localparam logic [CNT_W-1:0] LAST_IDX = 4'hF;
	localparam logic [CNT_W-1:0] SLEEP_IDX = 4'h2;

	// Reset values
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	localparam logic CS_N_RST = 1'b1;
	localparam logic SCK_RST = 1'b0;
	localparam logic POWERED_RST = 1'b1;

	// Serial output pin: level and output enable
	typedef struct packed {
		logic data;
		logic oe;
	} ssap_sdo_s;

	typedef enum logic [1:0] {
		SSAP_IDLE,
		SSAP_SHIFT,
		SSAP_DONE
	} ssap_state_e;

endpackage : ssap_pkg

// ### logic/ssap_port.sv
/*
 * Serial read-out port of a 12-bit sampling converter, device side.
 * Chip select and shift clock arrive as pins from the host; both are
 * synchronised to clk and their edges are found here. The converter core
 * delivers a stable result on sample_code; it is captured when a frame starts.
 * The pad combines serial_data_out.data and serial_data_out.oe into the pin.
 */
// Functional notes
// - Chip select falling starts a conversion; low chip select frames the transfer.
// - Conversion steps on each shift clock fall during the frame.
// - Serial output changes only on shift clock falls (and the framing chip select fall).
// - Frame is two zeros, twelve result bits MSB first, two zeros.
// - Output goes high impedance after the last fall or when chip select rises.
// - After sleep the core needs the wake delay before results are valid.
// - Chip select fall presents the first zero; each later fall the next bit.
// - A frame may end after 14 or 16 shift clock cycles.
// - Sleep is entered and left only by serial line activity.
module ssap_port
	import ssap_pkg::*;
#(
	parameter int WAKE_NS = WAKE_DELAY_NS
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [RES_W-1:0] sample_code,
	output ssap_sdo_s serial_data_out,
	output logic sample_strobe,
	output logic conv_step,
	output logic conv_done,
	output logic [RES_W-1:0] result_code,
	output logic powered
);

	localparam int WAKE_CYC_I = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CYC = (WAKE_CYC_I < 1) ? 1 : WAKE_CYC_I;
	localparam int WAKE_W = $clog2(WAKE_CYC + 1);
	localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_CYC[WAKE_W-1:0];
	localparam logic [WAKE_W-1:0] WAKE_ONE = 1;
	localparam logic [WAKE_W-1:0] WAKE_ZERO = '0;

	// Elaboration check: the 4-bit fall counter only serves a 16-bit frame
	if (WAKE_NS < 1 || WAKE_NS > 100000 || FRAME_W != 16) begin : g_bad_param
		$error("ssap_port: unsupported parameter values");
	end

	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic sck_meta_r;
	logic sck_sync_r;
	logic sck_prev_r;
	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	ssap_state_e state_r;
	logic [FRAME_W-1:0] frame_r;
	logic [CNT_W-1:0] bit_cnt_r;
	logic [RES_W-1:0] code_r;
	logic oe_r;
	logic strobe_r;
	logic step_r;
	logic done_r;
	logic powered_r;
	logic valid_frame_r;
	logic [WAKE_W-1:0] wake_cnt_r;

	// Three flops on each pin; edge detection compares the second and third flops
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_meta_r <= CS_N_RST;
			cs_sync_r <= CS_N_RST;
			cs_prev_r <= CS_N_RST;
			sck_meta_r <= SCK_RST;
			sck_sync_r <= SCK_RST;
			sck_prev_r <= SCK_RST;
		end else begin
			cs_meta_r <= cs_n;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
			sck_meta_r <= sck;
			sck_sync_r <= sck_meta_r;
			sck_prev_r <= sck_sync_r;
		end
	end

	// Edges of the synchronised pins
	assign cs_fall = cs_prev_r & ~cs_sync_r;
	assign cs_rise = ~cs_prev_r & cs_sync_r;
	assign sck_fall = sck_prev_r & ~sck_sync_r & ~cs_sync_r;

	// Frame sequencer; chip select rise always wins and ends the frame.
	// A chip select fall can only be seen in idle, since high chip select forces idle first.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= SSAP_IDLE;
		end else if (cs_sync_r) begin
			state_r <= SSAP_IDLE;
		end else begin
			unique case (state_r)
				SSAP_IDLE: begin
					if (cs_fall) begin
						state_r <= SSAP_SHIFT;
					end
				end
				SSAP_SHIFT: begin
					if (sck_fall && bit_cnt_r == LAST_IDX) begin
						state_r <= SSAP_DONE;
					end
				end
				SSAP_DONE: begin
					state_r <= SSAP_DONE; // Hold until chip select rises
				end
			endcase
		end
	end

	// Shift register and fall counter
	always_ff @(posedge clk) begin
		if (srst) begin
			frame_r <= '0;
			bit_cnt_r <= CNT_RST;
			code_r <= '0;
		end else if (cs_fall) begin
			frame_r <= {{LEAD_ZEROS{1'b0}}, sample_code, {TRAIL_ZEROS{1'b0}}};
			bit_cnt_r <= CNT_RST;
			code_r <= sample_code;
		end else if (state_r == SSAP_SHIFT && sck_fall && bit_cnt_r != LAST_IDX) begin
			frame_r <= {frame_r[FRAME_W-2:0], 1'b0};
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// Output enable: on at frame start, off after the 16th fall or at chip select rise
	always_ff @(posedge clk) begin
		if (srst) begin
			oe_r <= 1'b0;
		end else if (cs_sync_r) begin
			oe_r <= 1'b0;
		end else if (cs_fall) begin
			oe_r <= 1'b1;
		end else if (state_r == SSAP_SHIFT && sck_fall && bit_cnt_r == LAST_IDX) begin
			oe_r <= 1'b0;
		end
	end

	// Core strobes: sample at frame start, one step per fall, result after the 14th fall
	always_ff @(posedge clk) begin
		if (srst) begin
			strobe_r <= 1'b0;
			step_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			strobe_r <= cs_fall;
			step_r <= state_r == SSAP_SHIFT && sck_fall;
			done_r <= state_r == SSAP_SHIFT && sck_fall && bit_cnt_r == DONE_IDX
				&& valid_frame_r;
		end
	end

	// Sleep: a frame cut short before the second fall powers the core down.
	// The next chip select fall wakes it, but that frame's result is not valid.
	always_ff @(posedge clk) begin
		if (srst) begin
			powered_r <= POWERED_RST;
			valid_frame_r <= 1'b0;
			wake_cnt_r <= WAKE_ZERO;
		end else if (cs_rise && state_r == SSAP_SHIFT && bit_cnt_r < SLEEP_IDX) begin
			powered_r <= 1'b0;
			wake_cnt_r <= WAKE_ZERO;
		end else if (cs_fall && !powered_r && wake_cnt_r == WAKE_ZERO) begin
			wake_cnt_r <= WAKE_LOAD;
			valid_frame_r <= 1'b0;
		end else if (wake_cnt_r != WAKE_ZERO) begin
			wake_cnt_r <= wake_cnt_r - WAKE_ONE;
			powered_r <= wake_cnt_r == WAKE_ONE;
		end else if (cs_fall) begin
			valid_frame_r <= powered_r;
		end
	end

	// Result register updated with each completed conversion
	always_ff @(posedge clk) begin
		if (srst) begin
			result_code <= '0;
		end else if (state_r == SSAP_SHIFT && sck_fall && bit_cnt_r == DONE_IDX && valid_frame_r) begin
			result_code <= code_r;
		end
	end

	// One driver for the whole pin carrier
	assign serial_data_out = '{data: frame_r[FRAME_W-1], oe: oe_r};
	assign sample_strobe = strobe_r;
	assign conv_step = step_r;
	assign conv_done = done_r;
	assign powered = powered_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_frame_start;
		cs_fall;
	endsequence

	sequence s_first_zero;
		oe_r && !frame_r[FRAME_W-1] && bit_cnt_r == CNT_RST;
	endsequence

	property p_start;
		s_frame_start |=> s_first_zero;
	endproperty
	a_start: assert property (p_start) else $error("frame start not presented");

	property p_cs_hiz;
		cs_sync_r |=> !oe_r;
	endproperty
	a_cs_hiz: assert property (p_cs_hiz) else $error("output driven with chip select high");

	property p_change_on_fall;
		$changed(frame_r[FRAME_W-1]) && oe_r && $past(oe_r) |-> $past(sck_fall);
	endproperty
	a_change_on_fall: assert property (p_change_on_fall) else $error("data changed off a fall");

	property p_end_hiz;
		state_r == SSAP_SHIFT && sck_fall && bit_cnt_r == LAST_IDX |=> !oe_r && state_r != SSAP_SHIFT;
	endproperty
	a_end_hiz: assert property (p_end_hiz) else $error("output not released after last bit");

	property p_res_bits;
		oe_r && bit_cnt_r >= FIRST_RES_IDX && bit_cnt_r <= DONE_IDX
			|-> frame_r[FRAME_W-1] == code_r[DONE_IDX - bit_cnt_r];
	endproperty
	a_res_bits: assert property (p_res_bits) else $error("result bit wrong");

	property p_pad_zero;
		oe_r && (bit_cnt_r < FIRST_RES_IDX || bit_cnt_r > DONE_IDX) |-> !frame_r[FRAME_W-1];
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("padding bit not zero");

	property p_step;
		state_r == SSAP_SHIFT && sck_fall && bit_cnt_r != LAST_IDX
			|=> conv_step && bit_cnt_r == $past(bit_cnt_r) + 4'h1;
	endproperty
	a_step: assert property (p_step) else $error("conversion did not step");

	property p_done;
		state_r == SSAP_SHIFT && sck_fall && bit_cnt_r == DONE_IDX && valid_frame_r
			|=> conv_done ##1 !conv_done;
	endproperty
	a_done: assert property (p_done) else $error("result not delivered at 14th fall");

	property p_wake;
		$rose(powered_r) |-> $past(wake_cnt_r) == WAKE_ONE;
	endproperty
	a_wake: assert property (p_wake) else $error("woke before the wake delay");

	property p_sleep;
		cs_rise && state_r == SSAP_SHIFT && bit_cnt_r < SLEEP_IDX |=> !powered_r [*2];
	endproperty
	a_sleep: assert property (p_sleep) else $error("short frame did not enter sleep");

	property p_cs_start;
		s_frame_start |=> state_r == SSAP_SHIFT && sample_strobe;
	endproperty
	a_cs_start: assert property (p_cs_start) else $error("conversion not started");

endmodule : ssap_port
